// >>> common/stm_defines.svh
// Register map, field positions, reset values and timing counts of the
// supply threshold monitor control block.
// Assumes a 32-bit AXI4-Lite register bus on a 50 MHz clock.
`ifndef STM_DEFINES_SVH
`define STM_DEFINES_SVH

`define STM_ADDR_CONTROL 4'h0
`define STM_ADDR_STATUS 4'h4
`define STM_ADDR_MASK 4'h8

`define STM_BIT_DIRECTION 7
`define STM_BIT_BANDGAP 6
`define STM_BIT_REFSTABLE 5
`define STM_BIT_ENABLE 4
`define STM_TRIP_MSB 3
`define STM_TRIP_EXTERNAL 4'hF
`define STM_CONTROL_RESET 8'h05
`define STM_CONTROL_WMASK 8'h9F

`define STM_STAT_DETECT 0
`define STM_STAT_WAKE 1

`define STM_CLK_MHZ 50
`define STM_SETTLE_NS 1000
`define STM_SETTLE_CYCLES ((`STM_SETTLE_NS * `STM_CLK_MHZ + 999) / 1000)

`endif

// >>> common/stm_pkg.sv
// Types shared by the supply threshold monitor control block.
// Assumes nothing beyond a SystemVerilog compiler.
package stm_pkg;
  typedef enum logic [1:0] {
    STM_OFF,
    STM_SETTLING,
    STM_ARMED
  } stm_state_e;
  typedef logic [1:0] stm_resp_t;
endpackage

// >>> src/stm_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes the input is asynchronous to clk; output changes only when
// the second and third stages agree.
`timescale 1ns/1ps
module stm_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic async_in,
  output logic sync_out
);
  logic stage_a;
  logic stage_b;
  logic stage_c;

  // The first stage feeds only the second, to contain metastability.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage_a <= 1'b0;
      stage_b <= 1'b0;
      stage_c <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage_a <= async_in;
      stage_b <= stage_a;
      stage_c <= stage_b;
      if (stage_b == stage_c) begin
        sync_out <= stage_c;
      end
    end
  end
endmodule

// >>> src/stm_ctrl.sv
// Control and flag logic of a supply threshold monitor with an AXI4-Lite
// register slave. Assumes the analog comparator reports supply above trip
// as a level, and that the bandgap reports its stability as a level.
`timescale 1ns/1ps
`include "stm_defines.svh"

// Function
// - A crossing in the selected direction sets the detect flag.
// - An enabled detect flag raises the interrupt line toward the CPU.
// - One control register steers the monitor, bit 4 powering it.
// - Bit 7 set watches for rising supply, clear for falling supply.
// - Bit 6 reads back bandgap stability and ignores writes.
// - Bit 5 reads one only when detection may set the flag.
// - Bits 3 to 0 pick the trip level, code 1111 the external pin.
// - The flag can be set only after settling marks the reference stable.
// - The monitor runs in sleep and a crossing raises a wake request.
// - Reset returns the control register to its off state.
module stm_ctrl #(
  parameter int SETTLE_CYCLES = `STM_SETTLE_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic comparator_above,
  input wire logic bandgap_ready,
  input wire logic sleep_mode,
  output logic monitor_power,
  output logic external_trip_select,
  output logic [3:0] trip_level,
  output logic wake_request,
  output logic irq
);
  // The settle counter is sixteen bits wide, so refuse longer waits when
  // the block is elaborated rather than letting the count wrap.
  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535) begin
    $error("SETTLE_CYCLES out of range");
  end

  localparam stm_pkg::stm_resp_t RESP_OKAY = 2'h0;
  localparam stm_pkg::stm_resp_t RESP_SLVERR = 2'h2;
  localparam logic [15:0] SETTLE_LAST = 16'(SETTLE_CYCLES - 1);

  // Returns the byte-masked merge of write data into an old byte.
  function automatic logic [7:0] merge_byte(input logic [7:0] old_val,
                                            input logic [7:0] new_val,
                                            input logic strobe);
    merge_byte = strobe ? new_val : old_val;
  endfunction

  logic [7:0] detect_control_reg;
  logic [1:0] status;
  logic [1:0] mask;
  stm_pkg::stm_state_e state;
  stm_pkg::stm_state_e next_state;
  logic [15:0] settle_count;
  logic cmp_sync;
  logic bg_sync;
  logic cmp_prev;
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // Comparator and bandgap are analog levels from another domain.
  stm_sync u_sync_cmp (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(comparator_above),
    .sync_out(cmp_sync)
  );
  stm_sync u_sync_bg (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(bandgap_ready),
    .sync_out(bg_sync)
  );

  // Field views of the control register.
  wire enable = detect_control_reg[`STM_BIT_ENABLE];
  wire dir_rise = detect_control_reg[`STM_BIT_DIRECTION];
  wire [3:0] level = detect_control_reg[`STM_TRIP_MSB:0];
  wire ref_stable = (state == stm_pkg::STM_ARMED);

  // Crossing detection, qualified by the reference being stable.
  wire rise_edge = cmp_sync && !cmp_prev;
  wire fall_edge = !cmp_sync && cmp_prev;
  wire crossing = dir_rise ? rise_edge : fall_edge;
  wire detect_event = enable && ref_stable && crossing;
  wire wake_event = detect_event && sleep_mode;

  // Bus handshake decoding.
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire do_read = s_axi_arvalid && s_axi_arready;
  wire wr_ctrl = do_write && (aw_addr == `STM_ADDR_CONTROL);
  wire wr_stat = do_write && (aw_addr == `STM_ADDR_STATUS);
  wire wr_mask = do_write && (aw_addr == `STM_ADDR_MASK);
  wire wr_hit = wr_ctrl || wr_stat || wr_mask;
  wire rd_ctrl = s_axi_araddr == `STM_ADDR_CONTROL;
  wire rd_stat = s_axi_araddr == `STM_ADDR_STATUS;
  wire rd_mask = s_axi_araddr == `STM_ADDR_MASK;
  wire rd_hit = rd_ctrl || rd_stat || rd_mask;

  // Read-only bits are reflected live and never stored from the bus.
  wire [7:0] ctrl_view = {dir_rise, bg_sync, ref_stable, enable, level};
  wire [7:0] ctrl_new = merge_byte(detect_control_reg, w_data[7:0],
                                   w_strb[0]);
  wire [1:0] clear_bits = (wr_stat && w_strb[0]) ? w_data[1:0] : 2'h0;
  wire [1:0] set_bits = {wake_event, detect_event};
  wire [31:0] rd_word = rd_ctrl ? {24'h0, ctrl_view} :
                        rd_stat ? {30'h0, status} :
                        rd_mask ? {30'h0, mask} : 32'h0;

  // Settling sequencer: every enable restarts the stabilisation wait.
  always_comb begin
    next_state = state;
    case (state)
      stm_pkg::STM_OFF: begin
        if (enable) begin
          next_state = stm_pkg::STM_SETTLING;
        end
      end
      stm_pkg::STM_SETTLING: begin
        if (!enable) begin
          next_state = stm_pkg::STM_OFF;
        end else if (bg_sync && settle_count == SETTLE_LAST) begin
          next_state = stm_pkg::STM_ARMED;
        end
      end
      stm_pkg::STM_ARMED: begin
        if (!enable) begin
          next_state = stm_pkg::STM_OFF;
        end
      end
      default: begin
        next_state = stm_pkg::STM_OFF;
      end
    endcase
  end

  // Sequencer state and settle counter.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= stm_pkg::STM_OFF;
      settle_count <= 16'h0000;
      cmp_prev <= 1'b0;
    end else begin
      state <= next_state;
      cmp_prev <= cmp_sync;
      if (state != stm_pkg::STM_SETTLING || !bg_sync) begin
        settle_count <= 16'h0000;
      end else if (settle_count != SETTLE_LAST) begin
        settle_count <= settle_count + 16'h0001;
      end
    end
  end

  // Control register; only writable bits take bus data.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      detect_control_reg <= `STM_CONTROL_RESET;
    end else if (wr_ctrl) begin
      detect_control_reg <= ctrl_new & `STM_CONTROL_WMASK;
    end
  end

  // Sticky status with set winning over a same-cycle clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= 2'h0;
      mask <= 2'h0;
    end else begin
      status <= (status & ~clear_bits) | set_bits;
      if (wr_mask && w_strb[0]) begin
        mask <= w_data[1:0];
      end
    end
  end

  // Outputs toward the analog side and the CPU, all registered.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      monitor_power <= 1'b0;
      external_trip_select <= 1'b0;
      trip_level <= 4'h0;
      wake_request <= 1'b0;
      irq <= 1'b0;
    end else begin
      monitor_power <= enable;
      external_trip_select <= (level == `STM_TRIP_EXTERNAL);
      trip_level <= level;
      wake_request <= |(status & mask & 2'h2);
      irq <= |(status & mask);
    end
  end

  // Write channel: address and data are latched independently.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready;
      s_axi_wready <= !w_held && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  // Read channel: one read outstanding, data held until accepted.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (do_read) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// >>> verification/stm_ctrl_sva.sv
// Checker for the monitor control block: bus answers, flag and outputs.
// Assumes it is bound to stm_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module stm_ctrl_sva #(
  parameter int SETTLE_CYCLES = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic monitor_power,
  input wire logic external_trip_select,
  input wire logic [3:0] trip_level,
  input wire logic wake_request,
  input wire logic irq
);
  // One clock domain, so clock and reset are given once; only a_reset_off ignores the default reset.
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write not answered");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_ext_select: assert property (
    external_trip_select == (trip_level == 4'hF))
    else $error("external select wrong");
  a_wake_irq: assert property (
    wake_request |-> irq) else $error("wake without irq");
  a_irq_cause: assert property (
    $rose(irq) |-> $past(monitor_power) || $past(s_axi_bvalid))
    else $error("irq raised while off");
  a_irq_sticky: assert property (
    $fell(irq) |-> $past(s_axi_bvalid)) else $error("irq fell alone");
  a_reset_off: assert property (
    disable iff (1'b0) !aresetn |=> !monitor_power && !irq && !s_axi_bvalid)
    else $error("outputs live in reset");
endmodule

bind stm_ctrl stm_ctrl_sva #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_sva (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .monitor_power, .external_trip_select, .trip_level,
  .wake_request, .irq);

// >>> verification/stm_ctrl_test.sv
// Self-checking bench for the monitor control block over AXI4-Lite.
// Assumes a 50 MHz clock and the short settle count of 3 cycles.
`timescale 1ns/1ps
module stm_ctrl_test;
  logic aclk, aresetn, awv, wv, bready, arv, rready, cmp_above, bg, sleep;
  logic awready, wready, bvalid, arready, rvalid;
  logic power, ext, wake, irq;
  logic [3:0] awaddr, araddr, trip;
  logic [31:0] wdata, rdata, rv;
  logic [1:0] bresp, rresp, br, rr;
  logic [16:0] rows [4] = '{{8'h00, 8'h40, 1'b0}, {8'h8F, 8'hCF, 1'b1},
                           {8'hE7, 8'hC7, 1'b0}, {8'h0A, 8'h4A, 1'b0}};
  int err_total = 0, samples_checked = 0, cycles = 0;

  stm_ctrl #(.SETTLE_CYCLES(3)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .comparator_above(cmp_above),
    .bandgap_ready(bg), .sleep_mode(sleep), .monitor_power(power),
    .external_trip_select(ext), .trip_level(trip), .wake_request(wake),
    .irq(irq));

  // Free-running clock of 20 ns.
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // A hung handshake would stall forever, so a cycle ceiling ends the run.
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("compares %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  // Address and data go out together; each is dropped once it is taken.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
      got = bvalid;
      br = bresp;
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (arready) arv <= 1'b0;
      got = rvalid;
      rv = rdata;
      rr = rresp;
    end
    rready <= 1'b0;
  endtask

  // Edge detection trails the three-stage sync, so allow ten cycles.
  task automatic cmp(input logic v);
    @(posedge aclk);
    cmp_above <= v;
    repeat (10) @(posedge aclk);
  endtask

  // Main sequence: reset, table of control writes, then event cases.
  initial begin
    {aresetn, awv, wv, bready, arv, rready, cmp_above, sleep} = '0;
    {awaddr, araddr, wdata} = '0;
    bg = 1'b1;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(power, 1'b0);
    rd(4'h0);
    chk(rv, 32'h45);
    foreach (rows[i]) begin
      wr(4'h0, {24'h0, rows[i][16:9]});
      rd(4'h0);
      chk(rv, {24'h0, rows[i][8:1]});
      chk(trip, rows[i][12:9]);
      chk(ext, rows[i][0]);
      chk(power, 1'b0);
    end
    wr(4'hC, 32'h1);
    chk(br, 2'h2);
    rd(4'hC);
    chk(rr, 2'h2);
    chk(rv, 32'h0);
    wr(4'h8, 32'h1);
    wr(4'h0, 32'h95);
    repeat (20) @(posedge aclk);
    rd(4'h0);
    chk(rv, 32'hF5);
    chk(power, 1'b1);
    cmp(1'b1);
    chk(irq, 1'b1);
    cmp(1'b0);
    chk(irq, 1'b1);
    rd(4'h4);
    chk(rv, 32'h1);
    wr(4'h4, 32'h1);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0);
    // The bench disables before retuning so no false event appears.
    wr(4'h0, 32'h05);
    cmp(1'b1);
    wr(4'h0, 32'h15);
    repeat (20) @(posedge aclk);
    sleep <= 1'b1;
    wr(4'h8, 32'h3);
    cmp(1'b0);
    rd(4'h4);
    chk(rv, 32'h3);
    chk({wake, irq}, 2'h3);
    wr(4'h4, 32'h3);
    sleep <= 1'b0;
    cmp(1'b1);
    rd(4'h4);
    chk(rv, 32'h0);
    wr(4'h0, 32'h05);
    bg <= 1'b0;
    wr(4'h0, 32'h95);
    repeat (20) @(posedge aclk);
    rd(4'h0);
    chk(rv, 32'h95);
    cmp(1'b0);
    cmp(1'b1);
    rd(4'h4);
    chk(irq, 1'b0);
    chk(rv, 32'h0);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(power, 1'b0);
    // The bandgap is still low here, so only the reset fields read back.
    rd(4'h0);
    chk(rv, 32'h05);
    complete_run();
  end
endmodule
